// [src/erq_pkg.sv]
/*
 * erq_pkg: register map, field layout and carrier types of the
 * receive-frame qualifier. Assumes a 32-bit AHB-Lite register bus.
 */
`default_nettype none
package erq_pkg;
    // ************************************************************
    // register map: printed offsets are indices, byte = 4 * index
    // ************************************************************
    localparam logic [7:0] IDX_SUPPR  = 8'h05;
    localparam logic [7:0] IDX_SST    = 8'h06;
    localparam logic [7:0] IDX_RXCFG1 = 8'h0B;
    localparam logic [7:0] IDX_STATUS = 8'h10;
    localparam logic [7:0] IDX_MASK   = 8'h11;
    localparam logic [7:0] IDX_CTRL   = 8'h12;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int SUP_EN_BIT   = 7;
    localparam int SUP_RXS_BIT  = 6;
    localparam int SUP_THLD_LSB = 0;
    localparam int SST_LSB      = 0;
    localparam int RX_CH_BIT    = 7;
    localparam int RX_LP_LSB    = 4;
    localparam int RX_ZERO_LSB  = 0;
    localparam int CT_NOPAR_BIT = 0;
    localparam int CT_NOCRC_BIT = 1;
    localparam int CT_NRT_BIT   = 2;
    localparam int CT_PROTO_LSB = 3;
    localparam int EV_RXS       = 0;
    localparam int EV_SOFT      = 1;
    localparam int EV_RESTART   = 2;
    // ************************************************************
    // codes, reset values, counts
    // ************************************************************
    localparam logic [1:0] PROTO_OTHER = 2'h0;
    localparam logic [1:0] PROTO_A106  = 2'h1;
    localparam logic [1:0] PROTO_B106  = 2'h2;
    localparam logic [5:0] SC_CNT_MAX  = 6'h3F;
    localparam logic [7:0] RST_BYTE    = 8'h00;
    localparam logic [2:0] RST_EV      = 3'h0;
    typedef enum logic [2:0] {
        ERQ_RS_NONE   = 3'b000,
        ERQ_RS_SUPPR  = 3'b001,
        ERQ_RS_SST    = 3'b010,
        ERQ_RS_RXCFG1 = 3'b011,
        ERQ_RS_STATUS = 3'b100,
        ERQ_RS_MASK   = 3'b101,
        ERQ_RS_CTRL   = 3'b110
    } erq_rsel_t;
    typedef struct packed {
        logic       enable;
        logic       rxs_any;
        logic [3:0] thld;
    } erq_suppr_t;
    typedef struct packed {
        logic       channel;
        logic [2:0] lowpass_select;
        logic       zero_setting_a;
        logic       zero_setting_b;
        logic       zero_setting_c;
        logic       zero_setting_d;
    } erq_rxcfg_t;
    typedef struct packed {
        logic       no_par_rx;
        logic       no_crc_rx;
        logic       pay_nrt;
        logic [1:0] proto;
    } erq_ctrl_t;
endpackage
`default_nettype wire

// [src/erq_top.sv]
/*
 * erq_top: receive-frame qualifier with AHB-Lite register slave.
 * Assumes receiver event inputs are one-cycle pulses synchronous
 * to i_clk and a quarter-etu tick supplied by the framing timer.
 */
`default_nettype none
module erq_top (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic             o_hreadyout,
    output logic [31:0]      o_hrdata,
    output logic             o_hresp,
    input  wire logic        i_nibble_done,
    input  wire logic        i_nibble_err,
    input  wire logic        i_frame_end,
    input  wire logic [8:0]  i_byte_count,
    input  wire logic        i_rx_err,
    input  wire logic        i_par_err,
    input  wire logic        i_crc_err,
    input  wire logic        i_mrt_end,
    input  wire logic        i_qetu_tick,
    input  wire logic        i_subcarrier,
    input  wire logic        i_both_ch_en,
    input  wire logic        i_manual_sel,
    input  wire logic        i_auto_pm,
    output logic             o_am_en,
    output logic             o_pm_en,
    output logic             o_frame_pm,
    output erq_pkg::erq_rxcfg_t o_rxcfg,
    output erq_pkg::erq_ctrl_t  o_ctrl,
    output logic             o_suppress_en,
    output logic             o_discard,
    output logic             o_irq
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic                ready;
        logic [31:0]         rdata;
        logic                pend;
        logic                pwr;
        erq_pkg::erq_rsel_t  psel;
        erq_pkg::erq_suppr_t sup;
        logic [4:0]          sst;
        erq_pkg::erq_rxcfg_t rx;
        erq_pkg::erq_ctrl_t  ct;
        logic [2:0]          status;
        logic [2:0]          mask;
        logic                irq;
        logic                discard;
        logic                sc_run;
        logic [5:0]          sc_cnt;
        logic                am_en;
        logic                pm_en;
        logic                frame_pm;
    } erq_state_t;

    erq_state_t st_q;
    erq_state_t st_d;

    function automatic erq_pkg::erq_rsel_t decode(
        input logic [31:0] addr);
        erq_pkg::erq_rsel_t r;
        r = erq_pkg::ERQ_RS_NONE;
        if (addr[1:0] == 2'h0 && addr[31:10] == 22'h0) begin
            unique case (addr[9:2])
                erq_pkg::IDX_SUPPR:  r = erq_pkg::ERQ_RS_SUPPR;
                erq_pkg::IDX_SST:    r = erq_pkg::ERQ_RS_SST;
                erq_pkg::IDX_RXCFG1: r = erq_pkg::ERQ_RS_RXCFG1;
                erq_pkg::IDX_STATUS: r = erq_pkg::ERQ_RS_STATUS;
                erq_pkg::IDX_MASK:   r = erq_pkg::ERQ_RS_MASK;
                erq_pkg::IDX_CTRL:   r = erq_pkg::ERQ_RS_CTRL;
                default:             r = erq_pkg::ERQ_RS_NONE;
            endcase
        end
        return r;
    endfunction

    // ************************************************************
    // next state
    // ************************************************************
    logic [2:0] ev;
    logic       err;
    logic       short_f;
    logic       early;
    logic [7:0] wb;

    always_comb begin
        st_d = st_q;
        ev = 3'h0;
        wb = i_hwdata[7:0];
        st_d.discard = 1'b0;
        // one wait state: write lands before any later read
        if (st_q.pend) begin
            st_d.pend = 1'b0;
            st_d.ready = 1'b1;
            st_d.rdata = 32'h0;
            if (st_q.pwr) begin
                unique case (st_q.psel)
                    erq_pkg::ERQ_RS_SUPPR: begin
                        st_d.sup.enable = wb[erq_pkg::SUP_EN_BIT];
                        st_d.sup.rxs_any = wb[erq_pkg::SUP_RXS_BIT];
                        st_d.sup.thld = wb[erq_pkg::SUP_THLD_LSB+:4];
                    end
                    erq_pkg::ERQ_RS_SST:
                        st_d.sst = wb[erq_pkg::SST_LSB+:5];
                    erq_pkg::ERQ_RS_RXCFG1: st_d.rx = wb;
                    erq_pkg::ERQ_RS_MASK:   st_d.mask = wb[2:0];
                    erq_pkg::ERQ_RS_CTRL: begin
                        st_d.ct.no_par_rx = wb[erq_pkg::CT_NOPAR_BIT];
                        st_d.ct.no_crc_rx = wb[erq_pkg::CT_NOCRC_BIT];
                        st_d.ct.pay_nrt = wb[erq_pkg::CT_NRT_BIT];
                        st_d.ct.proto = wb[erq_pkg::CT_PROTO_LSB+:2];
                    end
                    erq_pkg::ERQ_RS_STATUS,
                    erq_pkg::ERQ_RS_NONE: ;
                endcase
            end else begin
                unique case (st_q.psel)
                    erq_pkg::ERQ_RS_SUPPR: st_d.rdata[7:0] =
                        {st_q.sup.enable, st_q.sup.rxs_any,
                         2'h0, st_q.sup.thld};
                    erq_pkg::ERQ_RS_SST:
                        st_d.rdata[7:0] = {3'h0, st_q.sst};
                    erq_pkg::ERQ_RS_RXCFG1: st_d.rdata[7:0] = st_q.rx;
                    erq_pkg::ERQ_RS_STATUS:
                        st_d.rdata[2:0] = st_q.status;
                    erq_pkg::ERQ_RS_MASK: st_d.rdata[2:0] = st_q.mask;
                    erq_pkg::ERQ_RS_CTRL:
                        st_d.rdata[4:0] = {st_q.ct.proto, st_q.ct.pay_nrt,
                            st_q.ct.no_crc_rx, st_q.ct.no_par_rx};
                    erq_pkg::ERQ_RS_NONE: ;
                endcase
            end
        end else if (i_hsel && i_htrans[1] && i_hready) begin
            st_d.pend = 1'b1;
            st_d.ready = 1'b0;
            st_d.pwr = i_hwrite;
            st_d.psel = decode(i_haddr);
        end

        // start interrupt: ISO-A 106 gates it on the first nibble
        if (i_nibble_done) begin
            if (st_q.ct.proto != erq_pkg::PROTO_A106 ||
                !i_nibble_err || st_q.sup.rxs_any) begin
                ev[erq_pkg::EV_RXS] = 1'b1;
            end
        end

        // frame end: crc / parity errors only count when checked
        err = i_rx_err | (i_crc_err & ~st_q.ct.no_crc_rx)
            | (i_par_err & ~st_q.ct.no_par_rx);
        short_f = i_byte_count < {5'h0, st_q.sup.thld};
        if (i_frame_end && err) begin
            // relies on software keeping crc / parity checked
            if (st_q.sup.enable && short_f) begin
                st_d.discard = 1'b1;
                ev[erq_pkg::EV_RESTART] = 1'b1;
            end else begin
                ev[erq_pkg::EV_SOFT] = 1'b1;
            end
        end

        // ISO-B subcarrier start window, quarter-etu resolution
        early = st_q.sc_cnt < {1'b0, st_q.sst};
        if (i_mrt_end) begin
            st_d.sc_run = 1'b1;
            st_d.sc_cnt = 6'h0;
        end else if (st_q.sc_run && i_subcarrier) begin
            st_d.sc_run = 1'b0;
            if (st_q.ct.proto == erq_pkg::PROTO_B106 && early) begin
                ev[erq_pkg::EV_SOFT] = 1'b1;
                if (st_q.sup.enable) begin
                    st_d.discard = 1'b1;
                    ev[erq_pkg::EV_RESTART] = 1'b1;
                end
            end
        end else if (st_q.sc_run && i_qetu_tick &&
                     st_q.sc_cnt != erq_pkg::SC_CNT_MAX) begin
            st_d.sc_cnt = st_q.sc_cnt + 6'h1;
        end

        // set wins over a write-one clear in the same cycle
        if (st_q.pend && st_q.pwr &&
            st_q.psel == erq_pkg::ERQ_RS_STATUS) begin
            st_d.status = st_q.status & ~wb[2:0];
        end
        st_d.status = st_d.status | ev;
        st_d.irq = |(st_d.status & st_d.mask);

        // channel routing; automatic choice comes from the receiver
        if (!i_both_ch_en) begin
            st_d.am_en = ~st_q.rx.channel;
            st_d.pm_en = st_q.rx.channel;
            st_d.frame_pm = st_q.rx.channel;
        end else begin
            st_d.am_en = 1'b1;
            st_d.pm_en = 1'b1;
            st_d.frame_pm = i_manual_sel ? st_q.rx.channel
                                         : i_auto_pm;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            st_q <= '0;
            st_q.ready <= 1'b1;
            st_q.am_en <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign o_hreadyout = st_q.ready;
    assign o_hrdata = st_q.rdata;
    assign o_hresp = 1'b0;
    assign o_am_en = st_q.am_en;
    assign o_pm_en = st_q.pm_en;
    assign o_frame_pm = st_q.frame_pm;
    assign o_rxcfg = st_q.rx;
    assign o_ctrl = st_q.ct;
    assign o_suppress_en = st_q.sup.enable;
    assign o_discard = st_q.discard;
    assign o_irq = st_q.irq;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    chk_discard_needs_en: assert property (
        o_discard |-> $past(st_q.sup.enable))
        else $error("discard without suppression enabled");
    chk_short_frame_drop: assert property (
        i_frame_end && i_rx_err && st_q.sup.enable &&
        i_byte_count < {5'h0, st_q.sup.thld} |=> o_discard)
        else $error("short bad frame not discarded");
    chk_long_frame_kept: assert property (
        i_frame_end && !(st_q.sc_run && i_subcarrier) &&
        (!st_q.sup.enable ||
         i_byte_count >= {5'h0, st_q.sup.thld}) |=> !o_discard)
        else $error("frame discarded unexpectedly");
    chk_crc_skip_drop: assert property (
        i_frame_end && i_crc_err && !i_rx_err && !i_par_err &&
        st_q.ct.no_crc_rx && !(st_q.sc_run && i_subcarrier)
        |=> !o_discard ##0 !$rose(st_q.status[erq_pkg::EV_SOFT]))
        else $error("skipped crc error still counted");
    chk_rxs_err_block: assert property (
        i_nibble_done && i_nibble_err && !st_q.sup.rxs_any &&
        st_q.ct.proto == erq_pkg::PROTO_A106
        |=> !$rose(st_q.status[erq_pkg::EV_RXS]))
        else $error("start interrupt despite nibble error");
    chk_rxs_err_pass: assert property (
        i_nibble_done && st_q.sup.rxs_any
        |=> st_q.status[erq_pkg::EV_RXS])
        else $error("start interrupt missing");
    chk_early_sc_soft: assert property (
        st_q.sc_run && i_subcarrier && !i_mrt_end &&
        st_q.ct.proto == erq_pkg::PROTO_B106 &&
        st_q.sc_cnt < {1'b0, st_q.sst}
        |=> st_q.status[erq_pkg::EV_SOFT])
        else $error("early subcarrier without soft error");
    chk_late_sc_quiet: assert property (
        st_q.sc_run && i_subcarrier && !i_frame_end &&
        st_q.sc_cnt >= {1'b0, st_q.sst}
        |=> !$rose(st_q.status[erq_pkg::EV_SOFT]))
        else $error("soft error on timely subcarrier");
    chk_single_channel: assert property (
        !i_both_ch_en |=> o_pm_en == $past(st_q.rx.channel)
                          && o_am_en != o_pm_en)
        else $error("wrong single channel");
    chk_reset_zero: assert property (disable iff (1'b0)
        !i_reset_n |=> o_rxcfg == '0 && !o_suppress_en && !o_irq)
        else $error("fields not zero after reset");
    chk_irq_level: assert property (
        o_irq == |(st_q.status & st_q.mask))
        else $error("interrupt output mismatch");

    cov_restart_irq: cover property (
        o_discard ##1 st_q.status[erq_pkg::EV_RESTART] && o_irq);
    cov_early_sc: cover property (
        i_mrt_end ##[1:20] (st_q.sc_run && i_subcarrier && early));
    cov_bus_write_read: cover property (
        st_q.pend && st_q.pwr ##[2:3] st_q.pend && !st_q.pwr);
endmodule
`default_nettype wire

// [dv/erq_card_model.sv]
/*
 * erq_card_model: card-side source of receiver events.
 * Assumes every task is entered just after a rising edge of i_clk.
 */
`default_nettype none
module erq_card_model (
    input  wire logic       i_clk,
    output var  logic       o_nib,
    output var  logic       o_nib_err,
    output var  logic       o_fend,
    output var  logic [8:0] o_bytes,
    output var  logic [2:0] o_errs,
    output var  logic       o_mrt,
    output var  logic       o_tick,
    output var  logic       o_sub
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {o_nib, o_nib_err, o_fend, o_mrt, o_tick, o_sub} = 6'h00;
        o_bytes = 9'h000;
        o_errs = 3'h0;
    end
    // stale qualifiers are inverted, never left looking valid
    task automatic nibble(input logic err);
        o_nib <= 1'b1;
        o_nib_err <= err;
        @(posedge i_clk);
        o_nib <= 1'b0;
        o_nib_err <= ~err;
    endtask
    task automatic frame(input logic [8:0] nb, input logic [2:0] e);
        o_fend <= 1'b1;
        o_bytes <= nb;
        o_errs <= e;
        @(posedge i_clk);
        o_fend <= 1'b0;
        o_bytes <= ~nb;
        o_errs <= ~e;
    endtask
    task automatic late_sub(input int t);
        o_mrt <= 1'b1;
        @(posedge i_clk);
        o_mrt <= 1'b0;
        repeat (t) begin
            o_tick <= 1'b1;
            @(posedge i_clk);
        end
        o_tick <= 1'b0;
        o_sub <= 1'b1;
        @(posedge i_clk);
        o_sub <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [dv/erq_top_test.sv]
/*
 * erq_top_test: self-checking bench of the receive qualifier.
 * Assumes erq_pkg and erq_card_model are compiled first.
 */
`default_nettype none
module erq_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] idx;
        logic [7:0] wd;
        logic [7:0] ex;
    } erq_row_t;
    localparam erq_row_t ROWS [7] = '{
        '{erq_pkg::IDX_SUPPR,  8'hFF, 8'hCF},
        '{erq_pkg::IDX_SST,    8'hFF, 8'h1F},
        '{erq_pkg::IDX_RXCFG1, 8'hA5, 8'hA5},
        '{erq_pkg::IDX_CTRL,   8'hFF, 8'h1F},
        '{erq_pkg::IDX_MASK,   8'hFF, 8'h07},
        '{erq_pkg::IDX_STATUS, 8'hFF, 8'h00},
        '{8'h30,               8'hFF, 8'h00}};
    logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h0;
    logic        both = 1'b0, man = 1'b0, apm = 1'b0;
    logic        hrdy, hresp, am, pm, fpm, sup, disc, irq;
    logic        nib, nerr, fend, mask_receive_timer, tick, sub;
    logic [2:0]  errs;
    logic [8:0]  nb;
    logic [7:0]  msk = 8'h07;
    erq_pkg::erq_rxcfg_t rxcfg;
    erq_pkg::erq_ctrl_t  ctrl;
    int          n_fail = 0, n_compared = 0;
    always #20 clk = ~clk;
    erq_card_model i_erq_card_model (.i_clk(clk), .o_nib(nib),
        .o_nib_err(nerr), .o_fend(fend), .o_bytes(nb), .o_errs(errs),
        .o_mrt(mask_receive_timer), .o_tick(tick), .o_sub(sub));
    erq_top i_erq_top (.i_clk(clk), .i_reset_n(rst_n), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hrdy),
        .o_hreadyout(hrdy), .o_hrdata(hrdata), .o_hresp(hresp),
        .i_nibble_done(nib), .i_nibble_err(nerr), .i_frame_end(fend),
        .i_byte_count(nb), .i_rx_err(errs[2]), .i_par_err(errs[1]),
        .i_crc_err(errs[0]), .i_mrt_end(mask_receive_timer), .i_qetu_tick(tick),
        .i_subcarrier(sub), .i_both_ch_en(both), .i_manual_sel(man),
        .i_auto_pm(apm), .o_am_en(am), .o_pm_en(pm), .o_frame_pm(fpm),
        .o_rxcfg(rxcfg), .o_ctrl(ctrl), .o_suppress_en(sup),
        .o_discard(disc), .o_irq(irq));
    // ****************************************
    // bus cycles and comparisons
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hsize <= 3'h2;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= w;
        // no cycle count assumed: each wait ends when hrdy is high, the hang guard bounds it
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hrdy !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, {24'h0, d});
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] ex);
        bus(1'b0, idx, 32'h0);
        chk(rd, {24'h0, ex});
    endtask
    // status is read, irq checked, then cleared by writing ones
    task automatic ev(input logic [7:0] st, input logic d);
        #1;
        chk({31'h0, disc}, {31'h0, d});
        @(posedge clk);
        rdchk(erq_pkg::IDX_STATUS, st);
        chk({31'h0, irq}, {31'h0, |(st & msk)});
        if (st != 8'h00) begin
            wr(erq_pkg::IDX_STATUS, st);
        end
    endtask
    task automatic print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({30'h0, am, pm}, 32'h2);
        foreach (ROWS[i]) begin
            rdchk(ROWS[i].idx, 8'h00);
            wr(ROWS[i].idx, ROWS[i].wd);
            rdchk(ROWS[i].idx, ROWS[i].ex);
        end
        chk({24'h0, rxcfg}, 32'hA5);
        chk({27'h0, ctrl}, 32'h1F);
        chk({31'h0, sup}, 32'h1);
        chk({30'h0, am, pm}, 32'h1);
        both <= 1'b1;
        man <= 1'b1;
        repeat (2) @(posedge clk);
        chk({29'h0, am, pm, fpm}, 32'h7);
        wr(erq_pkg::IDX_RXCFG1, 8'h25);
        @(posedge clk);
        chk({31'h0, fpm}, 32'h0);
        man <= 1'b0;
        apm <= 1'b1;
        repeat (2) @(posedge clk);
        chk({31'h0, fpm}, 32'h1);
        both <= 1'b0;
        wr(erq_pkg::IDX_CTRL, 8'h0C);
        wr(erq_pkg::IDX_SUPPR, 8'h84);
        i_erq_card_model.nibble(1'b1);
        ev(8'h00, 1'b0);
        i_erq_card_model.nibble(1'b0);
        ev(8'h01, 1'b0);
        wr(erq_pkg::IDX_SUPPR, 8'hC4);
        i_erq_card_model.nibble(1'b1);
        ev(8'h01, 1'b0);
        i_erq_card_model.frame(9'd3, 3'h4);
        ev(8'h04, 1'b1);
        i_erq_card_model.frame(9'd4, 3'h4);
        ev(8'h02, 1'b0);
        wr(erq_pkg::IDX_SUPPR, 8'h44);
        wr(erq_pkg::IDX_CTRL, 8'h0E);
        chk({31'h0, sup}, 32'h0);
        i_erq_card_model.frame(9'd2, 3'h1);
        ev(8'h00, 1'b0);
        wr(erq_pkg::IDX_CTRL, 8'h0C);
        i_erq_card_model.frame(9'd2, 3'h1);
        ev(8'h02, 1'b0);
        wr(erq_pkg::IDX_CTRL, 8'h14);
        rdchk(erq_pkg::IDX_CTRL, 8'h14);
        chk({27'h0, ctrl}, 32'h06);
        wr(erq_pkg::IDX_SUPPR, 8'h04);
        i_erq_card_model.nibble(1'b1);
        ev(8'h01, 1'b0);
        wr(erq_pkg::IDX_SST, 8'h04);
        wr(erq_pkg::IDX_SUPPR, 8'hC4);
        i_erq_card_model.late_sub(3);
        ev(8'h06, 1'b1);
        i_erq_card_model.late_sub(4);
        ev(8'h00, 1'b0);
        wr(erq_pkg::IDX_SUPPR, 8'h44);
        wr(erq_pkg::IDX_MASK, 8'h00);
        msk = 8'h00;
        i_erq_card_model.late_sub(0);
        ev(8'h02, 1'b0);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdchk(erq_pkg::IDX_SST, 8'h00);
        print_verdict;
    end
    // hang guard: the whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        print_verdict;
    end
endmodule
`default_nettype wire
